// >>> core/scw_pkg.sv
/*
 * Constants, register map and carrier types of the signed countdown watchdog.
 * Assumes a 125 MHz system clock and an Avalon-MM master that reaches the
 * registers with 32-bit data at word-aligned byte addresses.
 */
// Overview of operation
// - Count lives in an 8-bit down counter plus sign bit, minus one per 10.24 ms.
// - Reset loads the guard count with 255, about 2.6 s to the NMI at zero and 2.8 s to timeout.
// - Below zero bit 8 is set and counting goes on: 1, 0, 1FF ... 1F0.
// - With fault action select at 0, reaching zero raises the non-maskable interrupt.
// - With fault action select at 0, a count at or below -16 requests reset.
// - With fault action select at 1, a count at or below zero requests reset.
// - Timeout reset is a system reset restoring 255; it drives no other reset.
// - Debug halt status freezes the counter; software cannot override it.
// - Guard hold bit set freezes counting when select is 0; freeze clear resumes.
// - Fault action select is set by software only, cleared only by system reset.

package scw_pkg;

	// Timing
	localparam int unsigned CLOCK_PERIOD_PS = 8000;
	localparam int unsigned TICK_PERIOD_US  = 10240;
	localparam int unsigned TICK_CYCLES     = (TICK_PERIOD_US * 1000) / (CLOCK_PERIOD_PS / 1000);
	localparam int unsigned TICK_CNT_W      = 21;

	// Bus
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 32;

	// Register byte offsets
	localparam logic [4:0] OFS_GUARD_COUNT = 5'h00;
	localparam logic [4:0] OFS_CONTROL     = 5'h04;
	localparam logic [4:0] OFS_FREEZE_SET  = 5'h08;
	localparam logic [4:0] OFS_FREEZE_CLR  = 5'h0C;
	localparam logic [4:0] OFS_IRQ_STATUS  = 5'h10;
	localparam logic [4:0] OFS_IRQ_MASK    = 5'h14;
	localparam logic [4:0] OFS_STATUS      = 5'h18;

	// Guard count fields
	localparam int unsigned COUNT_W    = 9;
	localparam int unsigned SIGN_BIT   = 8;
	localparam int unsigned GUARD_LSB  = 9;
	localparam int unsigned GUARD_MSB  = 15;
	localparam logic [8:0]  COUNT_RESET = 9'h0FF;
	localparam logic [8:0]  COUNT_ZERO  = 9'h000;
	localparam logic [7:0]  NEG_LIMIT_LOW = 8'hF0;

	// Single-bit field positions
	localparam int unsigned CTRL_FAULT_SEL_BIT = 0;
	localparam int unsigned FRZ_HOLD_BIT       = 0;
	localparam int unsigned ST_HOLD_BIT        = 0;
	localparam int unsigned ST_DEBUG_BIT       = 1;
	localparam int unsigned ST_NEG_BIT         = 2;

	// Interrupt layout, shared by status and mask
	localparam int unsigned EVT_W         = 2;
	localparam logic [1:0]  EVT_RESET_VAL = 2'h0;

	typedef struct packed {
		logic timeout;
		logic nmi;
	} scw_evt_t;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [3:0]        byteenable;
		logic [DATA_W-1:0] writedata;
	} scw_bus_req_t;

	typedef enum logic [0:0] {
		SCW_BUS_WAIT = 1'b0,
		SCW_BUS_ACK  = 1'b1
	} scw_bus_state_t;

endpackage : scw_pkg

// >>> core/scw_tick.sv
/*
 * Tick divider: one-cycle pulse every CYCLES clocks.
 * Assumes a free-running clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps

module scw_tick #(
	parameter int unsigned CYCLES = scw_pkg::TICK_CYCLES
) (
	input  wire logic i_clock,
	input  wire logic i_reset,
	output logic      o_tick_q
);

	localparam logic [scw_pkg::TICK_CNT_W-1:0] LAST =
		scw_pkg::TICK_CNT_W'(CYCLES - 1);

	logic [scw_pkg::TICK_CNT_W-1:0] cnt_q;

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			cnt_q <= '0;
		end else if (cnt_q == LAST) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_tick_q <= 1'b0;
		end else begin
			o_tick_q <= (cnt_q == LAST);
		end
	end

endmodule : scw_tick

// >>> core/scw_watchdog.sv
/*
 * Signed countdown watchdog with Avalon-MM register slave.
 * Holds the 9-bit signed guard count, the fault action select, the software
 * hold, and a sticky interrupt status with mask.
 * Assumes i_reset is the system reset (it returns after a timeout request),
 * i_debug_halt is synchronous to i_clock, and the master obeys waitrequest.
 */
`timescale 1ns/1ps

module scw_watchdog #(
	parameter int unsigned TICK_CYCLES = scw_pkg::TICK_CYCLES
) (
	input  wire logic                       i_clock,
	input  wire logic                       i_reset,
	input  wire logic [scw_pkg::ADDR_W-1:0] i_avs_address,
	input  wire logic                       i_avs_read,
	input  wire logic                       i_avs_write,
	input  wire logic [3:0]                 i_avs_byteenable,
	input  wire logic [scw_pkg::DATA_W-1:0] i_avs_writedata,
	output logic      [scw_pkg::DATA_W-1:0] o_avs_readdata,
	output logic                            o_avs_waitrequest,
	input  wire logic                       i_debug_halt,
	output logic                            o_nmi,
	output logic                            o_timeout_system_reset,
	output logic                            o_irq
);

	scw_pkg::scw_bus_req_t   req;
	scw_pkg::scw_bus_state_t bus_q;

	logic [scw_pkg::COUNT_W-1:0] count_q;
	logic [scw_pkg::COUNT_W-1:0] count_dec;
	logic                        fault_sel_q;
	logic                        hold_q;
	logic                        tick;
	logic                        frozen;
	logic                        step;
	logic                        hit_zero;
	logic                        neg_limit;
	logic                        le_zero;
	logic                        timeout;
	logic                        nmi_evt;

	scw_pkg::scw_evt_t status_q;
	scw_pkg::scw_evt_t mask_q;
	scw_pkg::scw_evt_t events;
	scw_pkg::scw_evt_t w1c;

	logic                        wr_acc;
	logic                        rd_acc;
	logic                        wr_lane0;
	logic                        wr_count;
	logic                        guard_clean;
	logic [scw_pkg::DATA_W-1:0]  rd_mux;

	// Bundle the bus request so decode reads one carrier
	assign req.read       = i_avs_read;
	assign req.write      = i_avs_write;
	assign req.address    = i_avs_address;
	assign req.byteenable = i_avs_byteenable;
	assign req.writedata  = i_avs_writedata;

	// 10.24 ms time base
	scw_tick #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.i_clock  (i_clock),
		.i_reset  (i_reset),
		.o_tick_q (tick)
	);

	// Bus handshake: every access waits exactly one cycle, then completes.
	// The fixed wait gives read data a full cycle from the address decode.
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			bus_q <= scw_pkg::SCW_BUS_WAIT;
		end else begin
			unique case (bus_q)
				scw_pkg::SCW_BUS_WAIT: begin
					if (req.read || req.write) begin
						bus_q <= scw_pkg::SCW_BUS_ACK;
					end
				end
				scw_pkg::SCW_BUS_ACK: begin
					bus_q <= scw_pkg::SCW_BUS_WAIT;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_avs_waitrequest <= !((bus_q == scw_pkg::SCW_BUS_WAIT) &&
				(req.read || req.write));
		end
	end

	// Writes act in the ACK cycle, where waitrequest is low; reads are captured in the WAIT cycle before it
	assign wr_acc   = (bus_q == scw_pkg::SCW_BUS_ACK) && req.write;
	assign rd_acc   = (bus_q == scw_pkg::SCW_BUS_WAIT) && req.read;
	assign wr_lane0 = wr_acc && req.byteenable[0];

	// Count write needs both low lanes so the guard field is always seen
	assign guard_clean =
		(req.writedata[scw_pkg::GUARD_MSB:scw_pkg::GUARD_LSB] == '0);
	assign wr_count = wr_acc && (req.address == scw_pkg::OFS_GUARD_COUNT) &&
		(req.byteenable[1:0] == 2'h3) && guard_clean;

	// Freeze sources: debug halt cannot be masked by software
	assign frozen = i_debug_halt || (hold_q && !fault_sel_q);
	assign step   = tick && !frozen;

	// Nine-bit wrap turns 000 into 1FF, setting the sign bit
	assign count_dec = count_q - 1'b1;

	// Zero reached by counting down, not by a software load
	// A reload in the same cycle wins over the tick, so no zero is reached then
	assign hit_zero = step && !wr_count && (count_dec == scw_pkg::COUNT_ZERO);

	// Signed compares on the stored count
	assign neg_limit = count_q[scw_pkg::SIGN_BIT] &&
		(count_q[7:0] <= scw_pkg::NEG_LIMIT_LOW);
	assign le_zero = count_q[scw_pkg::SIGN_BIT] ||
		(count_q == scw_pkg::COUNT_ZERO);

	assign timeout = fault_sel_q ? le_zero : neg_limit;
	assign nmi_evt = hit_zero && !fault_sel_q && !timeout;

	// Guard count. A timeout acts as a system reset of this block, so the
	// count returns to its reset value at once instead of waiting for
	// i_reset to come back round.
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			count_q <= scw_pkg::COUNT_RESET;
		end else if (timeout) begin
			count_q <= scw_pkg::COUNT_RESET;
		end else if (wr_count) begin
			// A software reload beats a tick in the same cycle
			count_q <= req.writedata[scw_pkg::COUNT_W-1:0];
		end else if (step) begin
			count_q <= count_dec;
		end
	end

	// Fault action select: set-only from software
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			fault_sel_q <= 1'b0;
		end else if (timeout) begin
			fault_sel_q <= 1'b0;
		end else if (wr_lane0 && (req.address == scw_pkg::OFS_CONTROL) &&
			req.writedata[scw_pkg::CTRL_FAULT_SEL_BIT]) begin
			fault_sel_q <= 1'b1;
		end
	end

	// Software hold, set and cleared through separate registers
	always_ff @(posedge i_clock) begin
		if (i_reset || timeout) begin
			hold_q <= 1'b0;
		end else if (wr_lane0 && (req.address == scw_pkg::OFS_FREEZE_SET) &&
			req.writedata[scw_pkg::FRZ_HOLD_BIT]) begin
			hold_q <= 1'b1;
		end else if (wr_lane0 && (req.address == scw_pkg::OFS_FREEZE_CLR) &&
			req.writedata[scw_pkg::FRZ_HOLD_BIT]) begin
			hold_q <= 1'b0;
		end
	end

	// Non-maskable interrupt: one-cycle pulse as the count lands on zero
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_nmi <= 1'b0;
		end else begin
			o_nmi <= nmi_evt;
		end
	end

	// Timeout request: one-cycle pulse; only the system reset is driven
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_timeout_system_reset <= 1'b0;
		end else begin
			o_timeout_system_reset <= timeout;
		end
	end

	// Sticky events, set wins over a write-one-to-clear in the same cycle.
	// Status survives the internal timeout so software can read the cause
	// if the system reset does not reach this block.
	assign events.nmi     = nmi_evt;
	assign events.timeout = timeout;
	assign w1c = (wr_lane0 && (req.address == scw_pkg::OFS_IRQ_STATUS)) ?
		scw_pkg::scw_evt_t'(req.writedata[scw_pkg::EVT_W-1:0]) :
		scw_pkg::scw_evt_t'(scw_pkg::EVT_RESET_VAL);

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			status_q <= scw_pkg::scw_evt_t'(scw_pkg::EVT_RESET_VAL);
		end else begin
			status_q <= (status_q & ~w1c) | events;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			mask_q <= scw_pkg::scw_evt_t'(scw_pkg::EVT_RESET_VAL);
		end else if (wr_lane0 && (req.address == scw_pkg::OFS_IRQ_MASK)) begin
			mask_q <= scw_pkg::scw_evt_t'(req.writedata[scw_pkg::EVT_W-1:0]);
		end
	end

	// Level interrupt, one cycle behind the status it reflects
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(status_q & mask_q);
		end
	end

	// Read mux; unmapped or misaligned addresses read zero
	always_comb begin
		rd_mux = '0;
		unique case (req.address)
			scw_pkg::OFS_GUARD_COUNT: begin
				rd_mux[scw_pkg::COUNT_W-1:0] = count_q;
			end
			scw_pkg::OFS_CONTROL: begin
				rd_mux[scw_pkg::CTRL_FAULT_SEL_BIT] = fault_sel_q;
			end
			scw_pkg::OFS_FREEZE_SET: begin
				rd_mux[scw_pkg::FRZ_HOLD_BIT] = hold_q;
			end
			scw_pkg::OFS_FREEZE_CLR: begin
				rd_mux[scw_pkg::FRZ_HOLD_BIT] = hold_q;
			end
			scw_pkg::OFS_IRQ_STATUS: begin
				rd_mux[scw_pkg::EVT_W-1:0] = status_q;
			end
			scw_pkg::OFS_IRQ_MASK: begin
				rd_mux[scw_pkg::EVT_W-1:0] = mask_q;
			end
			scw_pkg::OFS_STATUS: begin
				rd_mux[scw_pkg::ST_HOLD_BIT]  = frozen;
				rd_mux[scw_pkg::ST_DEBUG_BIT] = i_debug_halt;
				rd_mux[scw_pkg::ST_NEG_BIT]   = count_q[scw_pkg::SIGN_BIT];
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	// Read data captured as waitrequest drops; reads have no side effect
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_avs_readdata <= '0;
		end else if (rd_acc) begin
			o_avs_readdata <= rd_mux;
		end
	end

endmodule : scw_watchdog

// >>> dv/scw_watchdog_assertions.sv
/*
 * Port checker of the signed countdown watchdog, bound into scw_watchdog.
 * Assumes one clock and the synchronous active-high system reset.
 */
`timescale 1ns/1ps

module scw_watchdog_assertions #(
	parameter int unsigned TICK_CYCLES = scw_pkg::TICK_CYCLES
) (
	input wire logic                       i_clock,
	input wire logic                       i_reset,
	input wire logic [scw_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic                       i_avs_read,
	input wire logic                       i_avs_write,
	input wire logic [3:0]                 i_avs_byteenable,
	input wire logic [scw_pkg::DATA_W-1:0] i_avs_writedata,
	input wire logic [scw_pkg::DATA_W-1:0] o_avs_readdata,
	input wire logic                       o_avs_waitrequest,
	input wire logic                       i_debug_halt,
	input wire logic                       o_nmi,
	input wire logic                       o_timeout_system_reset,
	input wire logic                       o_irq
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);

	a_wait_one_cycle:
	assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("waitrequest did not drop after one cycle");
	a_wait_back_high:
	assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest stayed low");
	a_read_data_stands:
	assert property (!(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
		else $error("read data changed without a read");
	a_nmi_one_pulse:
	assert property (o_nmi |=> !o_nmi[*7])
		else $error("nmi pulses closer than one tick");
	a_timeout_one_pulse:
	assert property (o_timeout_system_reset |=> !o_timeout_system_reset)
		else $error("timeout request longer than one cycle");
	a_timeout_no_nmi:
	assert property (o_timeout_system_reset |-> !o_nmi)
		else $error("nmi together with timeout request");
	a_halt_blocks_nmi:
	assert property (o_nmi |-> !$past(i_debug_halt))
		else $error("nmi from a decrement while halted");
	a_reset_quiet:
	assert property (disable iff (1'h0) i_reset |=> o_avs_waitrequest && !o_nmi && !o_irq
		&& !o_timeout_system_reset) else $error("outputs active after reset");
	a_irq_needs_event:
	assert property ($rose(o_irq) |-> $past(i_avs_write, 2) || $past(o_nmi)
		|| $past(o_timeout_system_reset)) else $error("irq rose without a cause");

	c_nmi: cover property (o_nmi);
	c_timeout: cover property (o_timeout_system_reset);
	c_irq: cover property ($rose(o_irq));
endmodule : scw_watchdog_assertions

bind scw_watchdog scw_watchdog_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.i_clock(i_clock), .i_reset(i_reset), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_byteenable(i_avs_byteenable),
	.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_debug_halt(i_debug_halt), .o_nmi(o_nmi),
	.o_timeout_system_reset(o_timeout_system_reset), .o_irq(o_irq));

// >>> dv/tb_signed_countdown_watchdog.sv
/*
 * Self-checking bench of the signed countdown watchdog.
 * Assumes the design in core/ and a short tick of 8 clocks.
 */
`timescale 1ns/1ps

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_signed_countdown_watchdog;
	logic        i_clock, i_reset, i_avs_read, i_avs_write, i_debug_halt;
	logic [4:0]  i_avs_address;
	logic [3:0]  i_avs_byteenable;
	localparam int TB_TICK = 8;
	logic [31:0] i_avs_writedata, o_avs_readdata, v;
	logic        o_avs_waitrequest, o_nmi, o_timeout_system_reset, o_irq;
	int          bad_count, check_count, nmi_seen, to_seen, cyc, nmi_at, to_at, seed;
	logic [31:0] exp_q[$];

	scw_watchdog #(.TICK_CYCLES(TB_TICK)) dut (.i_clock(i_clock), .i_reset(i_reset),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_byteenable(i_avs_byteenable), .i_avs_writedata(i_avs_writedata),
		.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
		.i_debug_halt(i_debug_halt), .o_nmi(o_nmi),
		.o_timeout_system_reset(o_timeout_system_reset), .o_irq(o_irq));

	initial begin
		i_clock = 1'h0;
		forever #4 i_clock = ~i_clock;
	end

	// Watches pulses and completed reads; expected read data wait in exp_q
	always @(posedge i_clock) begin
		cyc++;
		if (o_nmi === 1'h1) begin
			nmi_seen++;
			nmi_at = cyc;
		end
		if (o_timeout_system_reset === 1'h1) begin
			to_seen++;
			to_at = cyc;
		end
		if (i_avs_read && o_avs_waitrequest === 1'h0 && exp_q.size() > 0)
			`CHK(o_avs_readdata, exp_q.pop_front())
	end

	task automatic print_verdict;
		if (bad_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict

	task automatic acc(input logic r, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clock);
		i_avs_read <= r;
		i_avs_write <= !r;
		i_avs_address <= a;
		i_avs_writedata <= d;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_avs_waitrequest !== 1'h0 && n < 50);
		if (n >= 50) bad_count++;
		i_avs_read <= 1'h0;
		i_avs_write <= 1'h0;
	endtask : acc

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		acc(1'h0, a, d);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		acc(1'h1, a, 32'h0);
	endtask : rd

	// Bounded wait for the n-th timeout request (t) or nmi pulse
	task automatic wait_cnt(input bit t, input int n, input int lim);
		repeat (lim) if ((t ? to_seen : nmi_seen) < n) @(posedge i_clock);
	endtask : wait_cnt

	initial begin
		repeat (20000) @(posedge i_clock);
		bad_count++;
		print_verdict();
	end

	initial begin
		i_reset = 1'h1;
		i_avs_read = 1'h0;
		i_avs_write = 1'h0;
		i_avs_address = 5'h00;
		i_avs_byteenable = 4'hF;
		i_avs_writedata = 32'h0;
		// Halted from the start so the tick cannot race the first reads
		i_debug_halt = 1'h1;
		seed = 32;
		repeat (5) @(posedge i_clock);
		i_reset <= 1'h0;
		rd(5'h00, 32'h0FF);
		rd(5'h04, 32'h0);
		rd(5'h1C, 32'h0);
		rd(5'h18, 32'h3);
		for (int k = 0; k < 4; k++) begin
			v = $random(seed) & 32'hFF;
			wr(5'h00, v);
			wr(5'h00, 32'hFFFFFFFF);
			rd(5'h00, v);
		end
		// Count write without both low lanes must be dropped
		i_avs_byteenable <= 4'h1;
		wr(5'h00, 32'h12);
		i_avs_byteenable <= 4'hF;
		rd(5'h00, v);
		wr(5'h00, 32'h1F1);
		repeat (5) @(posedge i_clock);
		`CHK(to_seen, 0)
		rd(5'h00, 32'h1F1);
		rd(5'h18, 32'h7);
		wr(5'h00, 32'h1F0);
		wait_cnt(1, 1, 10);
		`CHK(to_seen, 1)
		rd(5'h00, 32'h0FF);
		wr(5'h08, 32'h1);
		wr(5'h00, 32'h1);
		i_debug_halt <= 1'h0;
		repeat (40) @(posedge i_clock);
		`CHK(nmi_seen, 0)
		rd(5'h18, 32'h1);
		wr(5'h0C, 32'h1);
		wait_cnt(0, 1, 20);
		`CHK(nmi_seen, 1)
		wr(5'h00, 32'h2);
		wait_cnt(0, 2, 40);
		`CHK(nmi_seen, 2)
		`CHK(to_seen, 1)
		i_debug_halt <= 1'h1;
		wr(5'h10, 32'h3);
		wr(5'h00, 32'h1);
		i_debug_halt <= 1'h0;
		wait_cnt(0, 3, 20);
		wait_cnt(1, 2, 200);
		// Sixteen ticks from zero to 1F0, then one registered cycle to the request
		`CHK(to_at - nmi_at, 16 * TB_TICK + 1)
		i_debug_halt <= 1'h1;
		rd(5'h10, 32'h3);
		wr(5'h14, 32'h3);
		repeat (2) @(posedge i_clock);
		`CHK(o_irq, 1'h1)
		wr(5'h10, 32'h1);
		rd(5'h10, 32'h2);
		wr(5'h14, 32'h1);
		repeat (2) @(posedge i_clock);
		`CHK(o_irq, 1'h0)
		wr(5'h10, 32'h2);
		rd(5'h10, 32'h0);
		wr(5'h04, 32'h1);
		wr(5'h04, 32'h0);
		rd(5'h04, 32'h1);
		wr(5'h00, 32'h0);
		wait_cnt(1, 3, 10);
		`CHK(to_seen, 3)
		rd(5'h04, 32'h0);
		wr(5'h04, 32'h1);
		// Hold is set but must not freeze counting while select is 1
		wr(5'h08, 32'h1);
		rd(5'h08, 32'h1);
		wr(5'h00, 32'h1);
		i_debug_halt <= 1'h0;
		wait_cnt(1, 4, 30);
		`CHK(to_seen, 4)
		`CHK(nmi_seen, 3)
		print_verdict();
	end
endmodule : tb_signed_countdown_watchdog
